//--- hdl/bpe_pkg.sv
// Package for the bridge parity and system-error reporting block
package bpe_pkg;
  // APB register byte offsets
  localparam logic [7:0] BPE_CTRL_OFS = 8'h00;
  localparam logic [7:0] BPE_STAT_OFS = 8'h04;
  localparam logic [7:0] BPE_REASON_OFS = 8'h08;
  localparam logic [7:0] BPE_DISABLE_OFS = 8'h0C;
  localparam logic [7:0] BPE_LIMIT_OFS = 8'h10;

  // Control register bit positions
  localparam int BPE_CTL_PRI_PER = 0;
  localparam int BPE_CTL_SEC_PER = 1;
  localparam int BPE_CTL_SERR_EN = 2;
  localparam int BPE_CTL_SERR_FWD = 3;
  localparam int BPE_CTL_MTO_SERR = 4;
  localparam int BPE_CTL_W = 5;

  // Status register bit positions (write one to clear)
  localparam int BPE_STA_SIG_SERR = 0;
  localparam int BPE_STA_RCV_SERR = 1;

  // Event numbering, shared by reason and disable registers
  localparam int BPE_EV_PAR = 0;
  localparam int BPE_EV_TABORT = 1;
  localparam int BPE_EV_MABORT = 2;
  localparam int BPE_EV_PW_DISC = 3;
  localparam int BPE_EV_DW_DISC = 4;
  localparam int BPE_EV_DR_FAIL = 5;
  localparam int BPE_EV_MTO = 6;
  localparam int BPE_EV_FWD = 7;
  localparam int BPE_EV_N = 8;

  localparam logic [BPE_CTL_W-1:0] BPE_CTRL_RST = 5'h00;
  localparam logic [BPE_EV_N-1:0] BPE_DISABLE_RST = 8'h00;

  // Retry limit: 2^24 target retries by default
  localparam int BPE_RETRY_W = 25;
  localparam logic [BPE_RETRY_W-1:0] BPE_RETRY_LIMIT_RST = 25'h1000000;
  localparam int BPE_QUEUES = 3;

  typedef enum logic [1:0] {
    BPE_TT_READ,
    BPE_TT_POSTED,
    BPE_TT_DELAYED
  } bpe_ttype_e;

  // Data-phase observation from the bus engines
  typedef struct packed {
    logic valid;
    bpe_ttype_e ttype;
    logic upstream;
    logic sec_bus;
    logic as_target;
    logic err_seen;
    logic completion;
  } bpe_phase_s;

  // Per-queue retry observation; queue 0 posted, 1 delayed write, 2 delayed read
  typedef struct packed {
    logic retry;
    logic done;
  } bpe_retry_s;
endpackage : bpe_pkg

//--- hdl/bpe_top.sv
// Parity and system-error reporting logic of a two-port PCI bridge
//
// What this block does
// - Secondary parity error driven only as secondary write target or read initiator.
// - Secondary parity error needs the secondary parity-response bit.
// - Upstream delayed write completion with primary parity error drives secondary one.
// - Secondary data parity errors on listed transfers drive it; otherwise idle.
// - Parity system error only for posted writes seeing far-side parity error.
// - No parity system error when bridge itself detected it as target.
// - Parity system error needs both parity-response bits set.
// - Primary system error never driven without the system-error enable.
// - Every primary system error sets the signaled-system-error status bit.
// - Secondary system error forwarded when forward enable is set.
// - Secondary system error seen sets received-system-error status bit.
// - Target abort and master abort on posted write are separate causes.
// - Posted write discarded after retry limit raises system error.
// - Delayed write discarded after retry limit raises system error.
// - Delayed read failing after retry limit raises system error.
// - Master timeout on delayed transaction raises system error.
// - Master timeout gated by its own control enable, not the mask.
// - Reason register records the cause of each system error.
// - Per-event disable bits suppress system error for that event, except the timeout and forwarding bits, which have no effect.
//
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
module bpe_top
  import bpe_pkg::*;
(
  input wire logic CLOCK,
  input wire logic ARST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire bpe_phase_s PHASE,
  input wire logic PRI_PARITY_ERR_IN_N,
  input wire logic SEC_SYSTEM_ERR_IN_N,
  input wire logic TABORT_PW,
  input wire logic MABORT_PW,
  input wire logic MTO_DELAYED,
  input wire bpe_retry_s [BPE_QUEUES-1:0] RETRY,
  output logic [BPE_QUEUES-1:0] DISCARD,
  output logic SEC_PARITY_ERR_N,
  output logic SEC_PARITY_ERR_OE,
  output logic PRI_SYSTEM_ERR_N,
  output logic PRI_SYSTEM_ERR_OE
);

  logic rst_s1_q;
  logic rst_n;
  logic ppe_s1_q;
  logic ppe_q;
  logic sse_s1_q;
  logic sse_q;
  logic sse_prev_q;
  logic [BPE_CTL_W-1:0] ctrl_q;
  logic [BPE_EV_N-1:0] disable_q;
  logic [BPE_EV_N-1:0] reason_q;
  logic sig_serr_q;
  logic rcv_serr_q;
  logic [BPE_RETRY_W-1:0] limit_q;
  logic [BPE_RETRY_W-1:0] retry_cnt_q [BPE_QUEUES];
  logic [BPE_QUEUES-1:0] limit_hit;
  logic [BPE_EV_N-1:0] ev_raw;
  logic [BPE_EV_N-1:0] ev_pass;
  logic serr_fire;
  logic sec_perr_d;
  logic wr_en;
  logic rd_en;
  logic [31:0] rdata_d;

  // Reset release through two flops
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  // Pin synchronisers, active-low pins idle high
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      ppe_s1_q <= 1'b1;
      ppe_q <= 1'b1;
      sse_s1_q <= 1'b1;
      sse_q <= 1'b1;
      sse_prev_q <= 1'b1;
    end else begin
      ppe_s1_q <= PRI_PARITY_ERR_IN_N;
      ppe_q <= ppe_s1_q;
      sse_s1_q <= SEC_SYSTEM_ERR_IN_N;
      sse_q <= sse_s1_q;
      sse_prev_q <= sse_q;
    end
  end

  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction : addr_is

  assign wr_en = PSEL && PENABLE && PWRITE;
  assign rd_en = PSEL && !PENABLE && !PWRITE;

  // Secondary parity error decision
  always_comb begin
    sec_perr_d = 1'b0;
    if (PHASE.valid && ctrl_q[BPE_CTL_SEC_PER]) begin
      // Only as secondary write target or secondary read initiator
      if (PHASE.sec_bus && PHASE.err_seen) begin
        unique case (PHASE.ttype)
          BPE_TT_READ: sec_perr_d = !PHASE.upstream && !PHASE.as_target;
          BPE_TT_POSTED: sec_perr_d = PHASE.upstream && PHASE.as_target;
          BPE_TT_DELAYED: sec_perr_d = PHASE.upstream && PHASE.as_target;
        endcase
      end
      // Completion of upstream delayed write on the primary side
      if (PHASE.ttype == BPE_TT_DELAYED && PHASE.upstream && PHASE.completion
          && !ppe_q && ctrl_q[BPE_CTL_PRI_PER]) begin
        sec_perr_d = 1'b1;
      end
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      SEC_PARITY_ERR_N <= 1'b1;
      SEC_PARITY_ERR_OE <= 1'b0;
    end else begin
      SEC_PARITY_ERR_N <= !sec_perr_d;
      SEC_PARITY_ERR_OE <= sec_perr_d;
    end
  end

  // Retry counters per queue
  generate
    for (genvar g = 0; g < BPE_QUEUES; g++) begin : g_retry
      assign limit_hit[g] = RETRY[g].retry && (retry_cnt_q[g] + 25'h0000001 >= limit_q);
      always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
          retry_cnt_q[g] <= '0;
          DISCARD[g] <= 1'b0;
        end else begin
          DISCARD[g] <= limit_hit[g];
          if (RETRY[g].done || limit_hit[g]) begin
            retry_cnt_q[g] <= '0;
          end else if (RETRY[g].retry) begin
            retry_cnt_q[g] <= retry_cnt_q[g] + 25'h0000001;
          end
        end
      end
    end
  endgenerate

  // Event sources
  always_comb begin
    ev_raw = '0;
    // Far-side parity report on posted write, not self-detected as target
    ev_raw[BPE_EV_PAR] = PHASE.valid && PHASE.ttype == BPE_TT_POSTED && !PHASE.as_target
                         && (PHASE.upstream ? !ppe_q : (PHASE.sec_bus && PHASE.err_seen))
                         && ctrl_q[BPE_CTL_PRI_PER] && ctrl_q[BPE_CTL_SEC_PER];
    ev_raw[BPE_EV_TABORT] = TABORT_PW;
    ev_raw[BPE_EV_MABORT] = MABORT_PW;
    ev_raw[BPE_EV_PW_DISC] = limit_hit[0];
    ev_raw[BPE_EV_DW_DISC] = limit_hit[1];
    ev_raw[BPE_EV_DR_FAIL] = limit_hit[2];
    ev_raw[BPE_EV_MTO] = MTO_DELAYED && ctrl_q[BPE_CTL_MTO_SERR];
    ev_raw[BPE_EV_FWD] = !sse_q && ctrl_q[BPE_CTL_SERR_FWD];
    // Timeout and forwarding are not maskable here
    ev_pass = ev_raw & ~(disable_q & 8'h3F);
    serr_fire = |ev_pass && ctrl_q[BPE_CTL_SERR_EN];
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      PRI_SYSTEM_ERR_N <= 1'b1;
      PRI_SYSTEM_ERR_OE <= 1'b0;
    end else begin
      PRI_SYSTEM_ERR_N <= !serr_fire;
      PRI_SYSTEM_ERR_OE <= serr_fire;
    end
  end

  // Status and reason; a new event beats a same-cycle clear
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      sig_serr_q <= 1'b0;
      rcv_serr_q <= 1'b0;
      reason_q <= '0;
    end else begin
      if (wr_en && addr_is(PADDR, BPE_STAT_OFS)) begin
        if (PWDATA[BPE_STA_SIG_SERR]) sig_serr_q <= 1'b0;
        if (PWDATA[BPE_STA_RCV_SERR]) rcv_serr_q <= 1'b0;
      end
      if (wr_en && addr_is(PADDR, BPE_REASON_OFS)) begin
        reason_q <= reason_q & ~PWDATA[BPE_EV_N-1:0];
      end
      if (serr_fire) begin
        sig_serr_q <= 1'b1;
        if (wr_en && addr_is(PADDR, BPE_REASON_OFS)) begin
          reason_q <= (reason_q & ~PWDATA[BPE_EV_N-1:0]) | ev_pass;
        end else begin
          reason_q <= reason_q | ev_pass;
        end
      end
      if (!sse_q && sse_prev_q) begin
        rcv_serr_q <= 1'b1;
      end
    end
  end

  // Control registers
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= BPE_CTRL_RST;
      disable_q <= BPE_DISABLE_RST;
      limit_q <= BPE_RETRY_LIMIT_RST;
    end else if (wr_en) begin
      if (addr_is(PADDR, BPE_CTRL_OFS)) ctrl_q <= PWDATA[BPE_CTL_W-1:0];
      if (addr_is(PADDR, BPE_DISABLE_OFS)) disable_q <= PWDATA[BPE_EV_N-1:0];
      if (addr_is(PADDR, BPE_LIMIT_OFS)) begin
        limit_q <= (PWDATA[BPE_RETRY_W-1:0] == '0) ? 25'h0000001 : PWDATA[BPE_RETRY_W-1:0];
      end
    end
  end

  // Read mux, registered in setup so access completes in one cycle
  always_comb begin
    rdata_d = 32'h00000000;
    if (addr_is(PADDR, BPE_CTRL_OFS)) rdata_d[BPE_CTL_W-1:0] = ctrl_q;
    if (addr_is(PADDR, BPE_STAT_OFS)) rdata_d[1:0] = {rcv_serr_q, sig_serr_q};
    if (addr_is(PADDR, BPE_REASON_OFS)) rdata_d[BPE_EV_N-1:0] = reason_q;
    if (addr_is(PADDR, BPE_DISABLE_OFS)) rdata_d[BPE_EV_N-1:0] = disable_q;
    if (addr_is(PADDR, BPE_LIMIT_OFS)) rdata_d[BPE_RETRY_W-1:0] = limit_q;
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      PRDATA <= 32'h00000000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      if (rd_en) PRDATA <= rdata_d;
      PREADY <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && !(addr_is(PADDR, BPE_CTRL_OFS)
                 || addr_is(PADDR, BPE_STAT_OFS) || addr_is(PADDR, BPE_REASON_OFS)
                 || addr_is(PADDR, BPE_DISABLE_OFS) || addr_is(PADDR, BPE_LIMIT_OFS));
    end
  end
endmodule : bpe_top

//--- verification/bpe_far.sv
// Far-side bus model: error pins and bus event pulses
`timescale 1ns/1ps
module bpe_far
  import bpe_pkg::*;
(
  input wire logic clk,
  output logic pperr_n,
  output logic serr_n,
  output logic [2:0] ev,
  output bpe_retry_s [BPE_QUEUES-1:0] rty
);
  // Pins idle high through their pull-ups
  initial begin
    pperr_n = 1'b1;
    serr_n = 1'b1;
    ev = 3'h0;
    rty = '0;
  end
  task automatic pins(input logic p, input logic s);
    pperr_n <= p;
    serr_n <= s;
    @(posedge clk);
  endtask : pins
  // One-cycle events; caller sees the registered answer on return
  task automatic hit(input logic [2:0] e, input bpe_retry_s [2:0] r);
    ev <= e;
    rty <= r;
    @(posedge clk);
    ev <= 3'h0;
    rty <= '0;
    @(posedge clk);
  endtask : hit
endmodule : bpe_far

//--- verification/bpe_monitor.sv
// Checker for the error-reporting block, bound to its top
`timescale 1ns/1ps
module bpe_monitor
  import bpe_pkg::*;
(
  input wire logic CLOCK,
  input wire logic ARST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PREADY,
  input wire bpe_phase_s PHASE,
  input wire logic SEC_SYSTEM_ERR_IN_N,
  input wire logic TABORT_PW,
  input wire logic MTO_DELAYED,
  input wire bpe_retry_s [BPE_QUEUES-1:0] RETRY,
  input wire logic [BPE_QUEUES-1:0] DISCARD,
  input wire logic SEC_PARITY_ERR_N,
  input wire logic PRI_SYSTEM_ERR_N
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!ARST_N);
  // Shadows of control and mask, taken at the same access edge as the design
  logic [BPE_CTL_W-1:0] ctl_q;
  logic [5:0] dis_q;
  wire logic wr_ok = PSEL && PENABLE && PREADY && PWRITE;
  wire logic en = ctl_q[BPE_CTL_SERR_EN];
  // Bridge must be the read initiator, so a target-side read never counts
  wire logic rd_err = PHASE.valid && PHASE.ttype == BPE_TT_READ && !PHASE.upstream
    && PHASE.sec_bus && PHASE.err_seen && !PHASE.as_target;
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctl_q <= BPE_CTRL_RST;
      dis_q <= 6'h00;
    end else if (wr_ok && PADDR == BPE_CTRL_OFS) begin
      ctl_q <= PWDATA[BPE_CTL_W-1:0];
    end else if (wr_ok && PADDR == BPE_DISABLE_OFS) begin
      dis_q <= PWDATA[5:0];
    end
  end
  a_serr_needs_en: assert property (!PRI_SYSTEM_ERR_N |-> $past(en))
    else $error("system error driven while disabled");
  a_perr_needs_resp: assert property (
    !SEC_PARITY_ERR_N |-> $past(ctl_q[BPE_CTL_SEC_PER])) else $error("parity error ungated");
  a_tabort_serr: assert property (
    TABORT_PW && en && !dis_q[BPE_EV_TABORT] |=> !PRI_SYSTEM_ERR_N) else $error("abort lost");
  a_mto_serr: assert property (
    MTO_DELAYED && en && ctl_q[BPE_CTL_MTO_SERR] |=> !PRI_SYSTEM_ERR_N) else $error("mto lost");
  a_fwd_serr: assert property (
    $fell(SEC_SYSTEM_ERR_IN_N) && en && ctl_q[BPE_CTL_SERR_FWD] |-> ##[1:4] !PRI_SYSTEM_ERR_N)
    else $error("forward lost");
  a_disc_pulse: assert property (
    DISCARD[0] |-> $past(RETRY[0].retry) ##1 !DISCARD[0]) else $error("bad discard pulse");
  a_read_perr: assert property (
    rd_err && ctl_q[BPE_CTL_SEC_PER] |=> !SEC_PARITY_ERR_N) else $error("read parity lost");
  a_ready_slot: assert property (PSEL && !PENABLE |=> PREADY ##1 !PREADY)
    else $error("ready out of slot");
  c_serr: cover property (!PRI_SYSTEM_ERR_N);
  c_disc: cover property (DISCARD[2]);
  c_perr: cover property (!SEC_PARITY_ERR_N);
endmodule : bpe_monitor
bind bpe_top bpe_monitor mon (.CLOCK, .ARST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
  .PREADY, .PHASE, .SEC_SYSTEM_ERR_IN_N, .TABORT_PW, .MTO_DELAYED, .RETRY, .DISCARD,
  .SEC_PARITY_ERR_N, .PRI_SYSTEM_ERR_N);

//--- verification/bridge_parity_system_error_report_test.sv
// Self-checking bench for the parity and system-error block
`timescale 1ns/1ps
module bridge_parity_system_error_report_test;
  import bpe_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = 32'h0;
  logic [31:0] prd, rd;
  logic rdy, slv, sl, spe_n, pse_n, pp_n, ss_n, spe_oe, pse_oe;
  logic [2:0] ev, disc;
  bpe_phase_s ph = '0;
  bpe_retry_s [BPE_QUEUES-1:0] rty;
  int num_errors = 0;
  int cmp_count = 0;
  always #4 clk = ~clk;
  bpe_far far (.clk(clk), .pperr_n(pp_n), .serr_n(ss_n), .ev(ev), .rty(rty));
  bpe_top dut (
    .CLOCK(clk), .ARST_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(rdy), .PSLVERR(slv),
    .PHASE(ph), .PRI_PARITY_ERR_IN_N(pp_n), .SEC_SYSTEM_ERR_IN_N(ss_n),
    .TABORT_PW(ev[0]), .MABORT_PW(ev[1]), .MTO_DELAYED(ev[2]), .RETRY(rty),
    .DISCARD(disc), .SEC_PARITY_ERR_N(spe_n), .SEC_PARITY_ERR_OE(spe_oe),
    .PRI_SYSTEM_ERR_N(pse_n), .PRI_SYSTEM_ERR_OE(pse_oe)
  );
  task automatic stop_test();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Idle cycle after each transfer so no strobe is driven twice in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 16);
    rd = prd;
    sl = slv;
    if (rdy !== 1'b1) begin
      num_errors++;
      stop_test();
    end
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb
  // Secondary-bus data parity error; bridge is target when upstream
  task automatic par(input bpe_ttype_e t, input logic up, input logic e);
    ph <= '{1'b1, t, up, 1'b1, up, 1'b1, 1'b0};
    @(posedge clk);
    ph <= '0;
    @(posedge clk);
    chk({31'h0, spe_n}, {31'h0, e});
  endtask : par
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    apb(1'b0, BPE_LIMIT_OFS, 32'h0);
    chk(rd, 32'h0100_0000);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, sl}, 32'h1);
    far.hit(3'h1, '0);
    chk({31'h0, pse_n}, 32'h1);
    apb(1'b1, BPE_CTRL_OFS, 32'h4);
    far.hit(3'h1, '0);
    chk({31'h0, pse_n}, 32'h0);
    apb(1'b0, BPE_STAT_OFS, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, BPE_REASON_OFS, 32'h0);
    chk(rd, 32'h2);
    apb(1'b1, BPE_DISABLE_OFS, 32'h2);
    far.hit(3'h1, '0);
    chk({31'h0, pse_n}, 32'h1);
    far.hit(3'h2, '0);
    chk({31'h0, pse_n}, 32'h0);
    apb(1'b1, BPE_REASON_OFS, 32'hFF);
    far.hit(3'h4, '0);
    chk({31'h0, pse_n}, 32'h1);
    apb(1'b1, BPE_DISABLE_OFS, 32'h3F);
    apb(1'b1, BPE_CTRL_OFS, 32'h14);
    far.hit(3'h4, '0);
    chk({31'h0, pse_n}, 32'h0);
    apb(1'b0, BPE_REASON_OFS, 32'h0);
    chk(rd, 32'h40);
    apb(1'b1, BPE_REASON_OFS, 32'hFF);
    apb(1'b1, BPE_DISABLE_OFS, 32'h0);
    $display("test events done");
    apb(1'b1, BPE_CTRL_OFS, 32'hC);
    apb(1'b1, BPE_STAT_OFS, 32'h3);
    far.pins(1'b1, 1'b0);
    repeat (4) @(posedge clk);
    chk({31'h0, pse_n}, 32'h0);
    far.pins(1'b1, 1'b1);
    apb(1'b0, BPE_STAT_OFS, 32'h0);
    chk(rd, 32'h3);
    apb(1'b1, BPE_REASON_OFS, 32'hFF);
    $display("test forward done");
    apb(1'b1, BPE_LIMIT_OFS, 32'h2);
    for (int q = 0; q < 3; q++) begin
      far.hit(3'h0, 6'h02 << (2 * q));
      chk({29'h0, disc}, 32'h0);
      far.hit(3'h0, 6'h02 << (2 * q));
      chk({29'h0, disc}, 32'h1 << q);
      apb(1'b0, BPE_REASON_OFS, 32'h0);
      chk(rd, 32'h8 << q);
      apb(1'b1, BPE_REASON_OFS, 32'hFF);
    end
    far.hit(3'h0, 6'h02);
    far.hit(3'h0, 6'h01);
    far.hit(3'h0, 6'h02);
    chk({29'h0, disc}, 32'h0);
    $display("test retry done");
    apb(1'b1, BPE_CTRL_OFS, 32'h0);
    par(BPE_TT_READ, 1'b0, 1'b1);
    apb(1'b1, BPE_CTRL_OFS, 32'h2);
    par(BPE_TT_READ, 1'b0, 1'b0);
    par(BPE_TT_READ, 1'b1, 1'b1);
    par(BPE_TT_POSTED, 1'b1, 1'b0);
    par(BPE_TT_POSTED, 1'b0, 1'b1);
    par(BPE_TT_DELAYED, 1'b1, 1'b0);
    $display("test parity done");
    apb(1'b1, BPE_CTRL_OFS, 32'h7);
    par(BPE_TT_POSTED, 1'b0, 1'b1);
    chk({31'h0, pse_n}, 32'h0);
    chk({31'h0, pse_oe}, 32'h1);
    par(BPE_TT_DELAYED, 1'b0, 1'b1);
    chk({31'h0, pse_n}, 32'h1);
    far.pins(1'b0, 1'b1);
    repeat (2) @(posedge clk);
    // Primary parity pin low: only the self-detected target case remains
    par(BPE_TT_POSTED, 1'b1, 1'b0);
    chk({31'h0, pse_n}, 32'h1);
    ph <= '{1'b1, BPE_TT_DELAYED, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
    @(posedge clk);
    ph <= '0;
    @(posedge clk);
    chk({31'h0, spe_n}, 32'h0);
    chk({31'h0, spe_oe}, 32'h1);
    far.pins(1'b1, 1'b1);
    $display("test system parity done");
    stop_test();
  end
endmodule : bridge_parity_system_error_report_test
